// *** design/ubr_core.sv ***
`timescale 1ns/1ps
// How it works
// - transmit and receive run independently, full duplex
// - receive FIFO holds three bytes before overflow
// - data writes load transmit register only
// - data reads return receive FIFO head only
// - unmasked set flag raises the interrupt
// - flags stay set until software clears them
// - receive flag clear ignored while FIFO holds bytes
// - 16-bit timer, prescaler 1, 4, 12 or 48
// - generator control enables; port idle when disabled
// - timer counts up from 16-bit split reload
// - timer wrap reloads programmed value at once
// - bit time equals two timer overflows
// - start, 5-8 data LSB first, parity, stops
// - tx write starts frame; flag at stop start
module ubr_core #(
  parameter int FIFO_DEPTH = 3
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ubr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        rxd,
  output logic                             txd,
  output logic                             irq
);
  import ubr_pkg::*;

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(FIFO_DEPTH);
  localparam logic [PW-1:0] LAST = PW'(FIFO_DEPTH - 1);

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 15)
  begin : g_bad_depth
    $error("FIFO_DEPTH must be 1 to 15");
  end

  function automatic logic [5:0] ps_div(input logic [1:0] sel);
    case (sel)
      PS_DIV1:  ps_div = DIV_1;
      PS_DIV4:  ps_div = DIV_4;
      PS_DIV48: ps_div = DIV_48;
      default:  ps_div = DIV_12;
    endcase
  endfunction

  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = 8'hFF >> (2'h3 - len);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] pt);
    case (pt)
      PAR_EVEN: par_bit = ^d;
      PAR_ODD:  par_bit = ~^d;
      PAR_MARK: par_bit = 1'b1;
      default:  par_bit = 1'b0;
    endcase
  endfunction

  logic                 pready_reg, pslverr_reg, pop_ok_reg, irq_reg, txd_reg;
  logic [31:0]          prdata_reg;
  logic                 rx_meta_reg, rx_sync_reg, rx_prev_reg;
  logic [7:0]           bgc_reg, rlh_reg, rll_reg;
  ubr_fmt_s             fmt_reg;
  logic [NEV-1:0]       status_reg, mask_reg, ev_set, clr_raw, clr_eff;
  logic [7:0]           fifo_mem [FIFO_DEPTH];
  logic [PW-1:0]        wp_reg, rp_reg;
  logic [CW-1:0]        rx_count_reg;
  logic                 acc, wr, rd, tx_wr, pop, push_ok, ovf_ev, map_ok;
  logic [7:0]           rd_val;
  logic                 gen_en;
  logic [5:0]           div;
  logic [15:0]          reload;
  logic [5:0]           ps_cnt_reg [2];
  logic [15:0]          tmr_reg [2];
  logic                 tick [2];
  logic                 ovf [2];
  logic                 restart [2];
  ubr_rx_e              rx_state_reg;
  logic                 rx_half_reg, rx_push_reg, rx_perr_reg, rx_extra_reg;
  logic [3:0]           rx_cnt_reg;
  logic [7:0]           rx_sh_reg, rx_data_reg, rx_word;
  logic                 rx_sample;
  ubr_tx_e              tx_state_reg;
  logic                 tx_half_reg, tx_pend_reg, tx_ev_reg, tx_bound;
  logic [7:0]           tx_hold_reg;
  logic [FRAME_W-1:0]   tx_sh_reg, tx_frame;
  logic [3:0]           tx_idx_reg, nbits, stop_pos, total;
  logic                 has_pbit;

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign txd     = txd_reg;
  assign irq     = irq_reg;

  assign gen_en   = bgc_reg[BGC_EN];
  assign div      = ps_div(bgc_reg[BGC_PS_LSB +: 2]);
  assign reload   = {rlh_reg, rll_reg};
  assign nbits    = LEN_BASE + {2'h0, fmt_reg.len};
  assign has_pbit = fmt_reg.par_en | fmt_reg.extra_en;
  assign stop_pos = 4'h1 + nbits + {3'h0, has_pbit};
  // second stop bit exists only for 6 to 8 data bits
  assign total    = stop_pos + 4'h1 + {3'h0, fmt_reg.stop2 && (fmt_reg.len != 2'h0)};

  // one wait state so read data and pready both leave flops
  assign acc   = psel & penable & pready_reg;
  assign wr    = acc & pwrite;
  assign rd    = acc & ~pwrite;
  assign tx_wr = wr && (paddr == OFF_DATA);
  assign pop   = rd && (paddr == OFF_DATA) && pop_ok_reg;

  always_comb
  begin
    map_ok = 1'b1;
    rd_val = 8'h00;
    if (paddr == OFF_DATA)
      rd_val = (rx_count_reg != '0) ? fifo_mem[rp_reg] : 8'h00;
    else if (paddr == OFF_CTRL)
      rd_val = {3'h0, rx_extra_reg, status_reg};
    else if (paddr == OFF_FMT)
      rd_val = fmt_reg;
    else if (paddr == OFF_BGC)
      rd_val = bgc_reg;
    else if (paddr == OFF_RLH)
      rd_val = rlh_reg;
    else if (paddr == OFF_RLL)
      rd_val = rll_reg;
    else if (paddr == OFF_MASK)
      rd_val = {4'h0, mask_reg};
    else
      map_ok = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pop_ok_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel & penable & ~pready_reg)
      begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
        pslverr_reg <= ~map_ok;
        pop_ok_reg  <= (rx_count_reg != '0);
      end
      else
      begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_reg  <= FMT_RST;
      bgc_reg  <= BGC_RST;
      rlh_reg  <= RLD_RST;
      rll_reg  <= RLD_RST;
      mask_reg <= MASK_RST;
    end
    else if (clk_en && wr)
    begin
      if (paddr == OFF_FMT)
        fmt_reg <= pwdata[7:0];
      else if (paddr == OFF_BGC)
        bgc_reg <= pwdata[7:0];
      else if (paddr == OFF_RLH)
        rlh_reg <= pwdata[7:0];
      else if (paddr == OFF_RLL)
        rll_reg <= pwdata[7:0];
      else if (paddr == OFF_MASK)
        mask_reg <= pwdata[NEV-1:0];
    end
  end

  // rx pin synchroniser, prev flop only looks at the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      rx_meta_reg <= rxd;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // channel 0 paces tx, channel 1 is restarted on each rx start edge
  assign restart[0] = 1'b0;
  assign restart[1] = gen_en && (rx_state_reg == RX_IDLE) && rx_prev_reg && !rx_sync_reg;

  for (genvar i = 0; i < 2; i++)
  begin : g_tmr
    assign tick[i] = gen_en && (ps_cnt_reg[i] >= div - 6'h01);
    assign ovf[i]  = tick[i] && (tmr_reg[i] == TMR_TOP);
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ps_cnt_reg[i] <= 6'h00;
        tmr_reg[i]    <= 16'h0000;
      end
      else if (clk_en)
      begin
        if (!gen_en || restart[i])
        begin
          ps_cnt_reg[i] <= 6'h00;
          tmr_reg[i]    <= reload;
        end
        else if (tick[i])
        begin
          ps_cnt_reg[i] <= 6'h00;
          tmr_reg[i]    <= ovf[i] ? reload : tmr_reg[i] + 16'h0001;
        end
        else
        begin
          ps_cnt_reg[i] <= ps_cnt_reg[i] + 6'h01;
        end
      end
    end
  end

  // a bit lasts two overflows, giving the halving in the rate
  assign tx_bound  = ovf[0] && tx_half_reg;
  assign rx_sample = ovf[1] && !rx_half_reg;

  always_comb
  begin
    logic [7:0] d;
    d        = tx_hold_reg & len_mask(fmt_reg.len);
    tx_frame = '1;
    tx_frame[0] = 1'b0;
    for (int k = 0; k < 8; k++)
      if (k < int'(nbits))
        tx_frame[1 + k] = d[k];
    if (fmt_reg.par_en)
      tx_frame[1 + nbits] = par_bit(d, fmt_reg.par_type);
    else if (fmt_reg.extra_en)
      tx_frame[1 + nbits] = fmt_reg.tx_extra;
  end

  // format changes during a frame take effect mid-frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_reg <= TX_IDLE;
      tx_half_reg  <= 1'b0;
      tx_pend_reg  <= 1'b0;
      tx_ev_reg    <= 1'b0;
      tx_hold_reg  <= 8'h00;
      tx_sh_reg    <= '1;
      tx_idx_reg   <= 4'h0;
      txd_reg      <= 1'b1;
    end
    else if (clk_en)
    begin
      tx_ev_reg <= 1'b0;
      if (ovf[0])
        tx_half_reg <= ~tx_half_reg;
      if (!gen_en)
      begin
        tx_state_reg <= TX_IDLE;
        txd_reg      <= 1'b1;
        tx_half_reg  <= 1'b0;
      end
      else if (tx_bound)
      begin
        case (tx_state_reg)
          TX_IDLE:
          begin
            if (tx_pend_reg)
            begin
              txd_reg      <= 1'b0;
              tx_sh_reg    <= tx_frame >> 1;
              tx_idx_reg   <= 4'h1;
              tx_pend_reg  <= 1'b0;
              tx_state_reg <= TX_SEND;
            end
          end
          default:
          begin
            if (tx_idx_reg == total)
            begin
              tx_state_reg <= TX_IDLE;
              txd_reg      <= 1'b1;
            end
            else
            begin
              txd_reg    <= tx_sh_reg[0];
              tx_sh_reg  <= {1'b1, tx_sh_reg[FRAME_W-1:1]};
              tx_idx_reg <= tx_idx_reg + 4'h1;
              if (tx_idx_reg == stop_pos)
                tx_ev_reg <= 1'b1;
            end
          end
        endcase
      end
      if (tx_wr)
      begin
        tx_hold_reg <= pwdata[7:0];
        tx_pend_reg <= 1'b1;
      end
    end
  end

  assign rx_word = rx_sh_reg >> (2'h3 - fmt_reg.len);

  // receiver is fully separate from the transmitter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_reg <= RX_IDLE;
      rx_half_reg  <= 1'b0;
      rx_cnt_reg   <= 4'h0;
      rx_sh_reg    <= 8'h00;
      rx_data_reg  <= 8'h00;
      rx_push_reg  <= 1'b0;
      rx_perr_reg  <= 1'b0;
      rx_extra_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_push_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
      if (restart[1])
        rx_half_reg <= 1'b0;
      else if (ovf[1])
        rx_half_reg <= ~rx_half_reg;
      if (!gen_en)
        rx_state_reg <= RX_IDLE;
      else
      begin
        case (rx_state_reg)
          RX_IDLE:
            if (restart[1])
              rx_state_reg <= RX_START;
          RX_START:
            if (rx_sample)
            begin
              rx_cnt_reg   <= 4'h0;
              rx_state_reg <= rx_sync_reg ? RX_IDLE : RX_DATA;
            end
          RX_DATA:
            if (rx_sample)
            begin
              rx_sh_reg  <= {rx_sync_reg, rx_sh_reg[7:1]};
              rx_cnt_reg <= rx_cnt_reg + 4'h1;
              if (rx_cnt_reg == nbits - 4'h1)
                rx_state_reg <= has_pbit ? RX_PAR : RX_STOP;
            end
          RX_PAR:
            if (rx_sample)
            begin
              if (fmt_reg.par_en)
                rx_perr_reg <= rx_sync_reg != par_bit(rx_word, fmt_reg.par_type);
              else
                rx_extra_reg <= rx_sync_reg;
              rx_state_reg <= RX_STOP;
            end
          default:
            if (rx_sample)
            begin
              rx_data_reg  <= rx_word;
              rx_push_reg  <= 1'b1;
              rx_state_reg <= RX_IDLE;
            end
        endcase
      end
    end
  end

  assign push_ok = rx_push_reg && ((rx_count_reg != FULL) || pop);
  assign ovf_ev  = rx_push_reg && (rx_count_reg == FULL) && !pop;

  // storage carries no reset, so it stays out of the reset process
  always_ff @(posedge pclk)
  begin
    if (clk_en && push_ok)
      fifo_mem[wp_reg] <= rx_data_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_reg       <= '0;
      rp_reg       <= '0;
      rx_count_reg <= '0;
    end
    else if (clk_en)
    begin
      if (push_ok)
        wp_reg <= (wp_reg == LAST) ? '0 : wp_reg + PW'(1);
      if (pop)
        rp_reg <= (rp_reg == LAST) ? '0 : rp_reg + PW'(1);
      if (push_ok && !pop)
        rx_count_reg <= rx_count_reg + CW'(1);
      else if (pop && !push_ok)
        rx_count_reg <= rx_count_reg - CW'(1);
    end
  end

  always_comb
  begin
    ev_set          = '0;
    ev_set[ST_TX]   = tx_ev_reg;
    ev_set[ST_RX]   = push_ok;
    ev_set[ST_OVF]  = ovf_ev;
    ev_set[ST_PERR] = rx_perr_reg;
    clr_raw         = (wr && (paddr == OFF_CTRL)) ? pwdata[NEV-1:0] : '0;
    clr_eff         = clr_raw;
    if (rx_count_reg != '0)
      clr_eff[ST_RX] = 1'b0;
  end

  // set beats clear so no event is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= '0;
      irq_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      status_reg <= (status_reg & ~clr_eff) | ev_set;
      irq_reg    <= |(status_reg & mask_reg);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_fifo_bound: assert property (rx_count_reg <= FULL)
    else $error("receive fifo count above depth");
  chk_ovf_keeps_data: assert property ((clk_en && ovf_ev) |=> (rx_count_reg == FULL) && status_reg[ST_OVF])
    else $error("overflow lost stored bytes or flag");
  chk_write_no_rx: assert property ((clk_en && tx_wr && !rx_push_reg) |=> $stable(rx_count_reg))
    else $error("data write disturbed receive fifo");
  chk_rx_clear_block: assert property ((clk_en && clr_raw[ST_RX] && rx_count_reg != '0) |=> status_reg[ST_RX])
    else $error("receive flag cleared with bytes left");
  chk_flag_sticky: assert property ((clk_en && status_reg[ST_TX] && !clr_raw[ST_TX]) |=> status_reg[ST_TX])
    else $error("tx flag dropped without clear");
  chk_tmr_wrap: assert property ((clk_en && gen_en && ovf[0]) |=> tmr_reg[0] == $past(reload))
    else $error("timer not reloaded on wrap");
  chk_tmr_count: assert property ((clk_en && tick[0] && tmr_reg[0] != TMR_TOP)
                                  |=> tmr_reg[0] == $past(tmr_reg[0]) + 16'h0001)
    else $error("timer did not count up");
  chk_presc_gap: assert property ((clk_en && tick[0] && div == DIV_4 && ps_cnt_reg[0] == 6'h03)
                                  |=> (!tick[0] || !clk_en) [*3])
    else $error("prescaler tick too early");
  chk_disabled_idle: assert property ((clk_en && !gen_en) |=> txd_reg && rx_state_reg == RX_IDLE)
    else $error("port active while generator off");
  chk_tx_stop_flag: assert property ((clk_en && tx_ev_reg) |-> txd_reg ##1 status_reg[ST_TX])
    else $error("tx flag not set at stop bit");
  chk_irq_raise: assert property ((clk_en && (status_reg & mask_reg) != '0) |=> irq_reg)
    else $error("interrupt missing for unmasked flag");

  cov_overflow: cover property (clk_en && ovf_ev);
  cov_tx_frame: cover property (clk_en && tx_ev_reg);
  cov_rx_push: cover property (clk_en && push_ok && pop);
  cov_irq: cover property (irq_reg && status_reg[ST_RX]);
endmodule

// *** design/ubr_pkg.sv ***
package ubr_pkg;
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFF_DATA   = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_FMT    = 8'h08;
  localparam logic [7:0] OFF_BGC    = 8'h0C;
  localparam logic [7:0] OFF_RLH    = 8'h10;
  localparam logic [7:0] OFF_RLL    = 8'h14;
  localparam logic [7:0] OFF_MASK   = 8'h18;
  // status bits, mask uses the same layout
  localparam int         NEV        = 4;
  localparam int         ST_TX      = 0;
  localparam int         ST_RX      = 1;
  localparam int         ST_OVF     = 2;
  localparam int         ST_PERR    = 3;
  localparam int         CTRL_XBIT  = 4;
  // baud_gen_control fields
  localparam int         BGC_EN     = 0;
  localparam int         BGC_PS_LSB = 1;
  localparam int         BGC_SRC    = 3;
  localparam logic [1:0] PS_DIV12   = 2'h0;
  localparam logic [1:0] PS_DIV4    = 2'h1;
  localparam logic [1:0] PS_DIV48   = 2'h2;
  localparam logic [1:0] PS_DIV1    = 2'h3;
  localparam logic [5:0] DIV_1      = 6'h01;
  localparam logic [5:0] DIV_4      = 6'h04;
  localparam logic [5:0] DIV_12     = 6'h0C;
  localparam logic [5:0] DIV_48     = 6'h30;
  localparam logic [15:0] TMR_TOP   = 16'hFFFF;
  localparam logic [1:0] PAR_EVEN   = 2'h0;
  localparam logic [1:0] PAR_ODD    = 2'h1;
  localparam logic [1:0] PAR_MARK   = 2'h2;
  localparam logic [1:0] PAR_SPACE  = 2'h3;
  localparam logic [3:0] LEN_BASE   = 4'h5;
  localparam int         FRAME_W    = 12;
  localparam logic [7:0] BGC_RST    = 8'h00;
  localparam logic [7:0] RLD_RST    = 8'h00;
  localparam logic [7:0] FMT_RST    = 8'h03;
  localparam logic [NEV-1:0] MASK_RST = 4'h0;

  typedef struct packed {
    logic       tx_extra;
    logic       extra_en;
    logic       stop2;
    logic [1:0] par_type;
    logic       par_en;
    logic [1:0] len;
  } ubr_fmt_s;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ubr_rx_e;
  typedef enum logic {TX_IDLE, TX_SEND} ubr_tx_e;
endpackage

// *** dv/ubr_core_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin miscompares++; $display("Error %s expected %0h seen %0h", nm, ex, sn); end end
module ubr_core_test;
  import ubr_pkg::*;
  logic              pclk, presetn, clk_en, psel, penable, pwrite, rxd, txd, irq, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  int                miscompares = 0;
  int                n_compared = 0;
  int                c, e;
  logic [5:0]        dv [4] = '{DIV_1, DIV_4, DIV_12, DIV_48};
  logic [1:0]        pv [4] = '{PS_DIV1, PS_DIV4, PS_DIV12, PS_DIV48};
  int                nv [4] = '{16, 4, 2, 1};

  ubr_core i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  ubr_node i_node (.pclk(pclk), .line_in(txd), .line_out(rxd));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // no assumed wait count: only the watchdog ends a stuck access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    begin
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex, rd)
    end
  endtask

  // polling bounded so a stuck flag ends in a miscompare, not a hang
  task automatic wait_tx;
    int k;
    begin
      k = 0;
      apb(1'b0, OFF_CTRL, 32'h0);
      while (rd[ST_TX] !== 1'b1 && k < 800)
      begin
        apb(1'b0, OFF_CTRL, 32'h0);
        k++;
      end
    end
  endtask

  task automatic wait_rx(input int n);
    int k;
    begin
      k = 0;
      while (i_node.rx_cnt < n && k < 5000)
      begin
        @(posedge pclk);
        k++;
      end
      `CHK("node frames", n, i_node.rx_cnt)
    end
  endtask

  task close_out;
    begin
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial
  begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    $display("Error watchdog expected done seen timeout");
    close_out;
  end

  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("fmt", OFF_FMT, {24'h0, FMT_RST});
    rdc("bgc", OFF_BGC, {24'h0, BGC_RST});
    rdc("rlh", OFF_RLH, {24'h0, RLD_RST});
    rdc("rll", OFF_RLL, {24'h0, RLD_RST});
    rdc("mask", OFF_MASK, {28'h0, MASK_RST});
    rdc("empty data", OFF_DATA, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    i_node.send(8'h77);
    repeat (64) @(posedge pclk);
    rdc("rx while off", OFF_CTRL, 32'h0);
    wr(OFF_RLH, 32'hFF);
    wr(OFF_RLL, 32'hF0);
    wr(OFF_BGC, {29'h0, PS_DIV1, 1'b1});
    rdc("bgc back", OFF_BGC, {29'h0, PS_DIV1, 1'b1});
    c = i_node.rx_cnt;
    wr(OFF_DATA, 32'hA5);
    repeat (256) @(posedge pclk);
    rdc("no flag mid frame", OFF_CTRL, 32'h0);
    wait_tx;
    `CHK("flag at stop start", c, i_node.rx_cnt)
    `CHK("txd stop", 1'b1, txd)
    wait_rx(c + 1);
    `CHK("tx byte", 8'hA5, i_node.got)
    `CHK("tx stop", 1'b1, i_node.stop_lvl)
    rdc("rx untouched", OFF_DATA, 32'h0);
    repeat (200) @(posedge pclk);
    `CHK("irq masked", 1'b0, irq)
    rdc("tx sticky", OFF_CTRL, 32'h1);
    wr(OFF_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq tx", 1'b1, irq)
    wr(OFF_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    fork
      i_node.send(8'h5A);
      wr(OFF_DATA, 32'h3C);
    join
    wait_rx(c + 2);
    `CHK("duplex tx", 8'h3C, i_node.got)
    repeat (64) @(posedge pclk);
    rdc("duplex flags", OFF_CTRL, 32'h3);
    wr(OFF_MASK, 32'h2);
    wr(OFF_CTRL, 32'h3);
    rdc("rx clear held", OFF_CTRL, 32'h2);
    `CHK("irq rx", 1'b1, irq)
    i_node.send(8'h11);
    i_node.send(8'h22);
    repeat (64) @(posedge pclk);
    rdc("three held", OFF_CTRL, 32'h2);
    i_node.send(8'h33);
    repeat (64) @(posedge pclk);
    rdc("overflow", OFF_CTRL, 32'h6);
    rdc("fifo 0", OFF_DATA, 32'h5A);
    rdc("fifo 1", OFF_DATA, 32'h11);
    rdc("fifo 2", OFF_DATA, 32'h22);
    rdc("fifo empty", OFF_DATA, 32'h0);
    wr(OFF_CTRL, 32'h6);
    rdc("rx cleared", OFF_CTRL, 32'h0);
    // a frame that arrives while frozen must leave no trace
    clk_en <= 1'b0;
    i_node.send(8'h44);
    clk_en <= 1'b1;
    rdc("frozen rx", OFF_CTRL, 32'h0);
    wr(OFF_FMT, 32'h06);
    c = i_node.rx_cnt;
    wr(OFF_DATA, 32'h57);
    wait_rx(c + 1);
    `CHK("parity tx", 8'hD7, i_node.got)
    i_node.send(8'h57);
    repeat (64) @(posedge pclk);
    rdc("parity error", OFF_CTRL, 32'hB);
    rdc("seven bits", OFF_DATA, 32'h57);
    wr(OFF_FMT, 32'h03);
    wr(OFF_CTRL, 32'hF);
    for (int i = 0; i < 4; i++)
    begin
      e = 2 * int'(dv[i]) * nv[i];
      wr(OFF_RLL, 32'(256 - nv[i]));
      wr(OFF_BGC, {29'h0, pv[i], 1'b1});
      repeat (200) @(posedge pclk);
      i_node.bit_c = e;
      c = i_node.rx_cnt;
      wr(OFF_DATA, 32'h55);
      wait_rx(c + 1);
      `CHK("bit cycles", e, i_node.low_len)
      `CHK("scaled byte", 8'h55, i_node.got)
    end
    close_out;
  end
endmodule

// *** dv/ubr_node.sv ***
`timescale 1ns/1ps
module ubr_node (
  input  wire logic pclk,
  input  wire logic line_in,
  output logic      line_out
);
  int         bit_c = 32;
  int         rx_cnt = 0;
  int         low_len = 0;
  logic [7:0] got;
  logic       stop_lvl;

  initial line_out = 1'b1; // idle high between frames

  // start low, lsb first, one high stop
  task automatic send(input logic [7:0] b);
    int i;
    begin
      @(posedge pclk);
      line_out <= 1'b0;
      repeat (bit_c) @(posedge pclk);
      for (i = 0; i < 8; i++)
      begin
        line_out <= b[i];
        repeat (bit_c) @(posedge pclk);
      end
      line_out <= 1'b1;
      repeat (bit_c) @(posedge pclk);
    end
  endtask

  // mid-bit sampling on the falling clock edge keeps clear of txd updates
  always
  begin
    @(negedge line_in);
    repeat (bit_c / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_c) @(negedge pclk);
      got[i] = line_in;
    end
    repeat (bit_c) @(negedge pclk);
    stop_lvl = line_in;
    rx_cnt++;
  end

  // width of the latest low run, in pclk cycles
  always
  begin
    int k;
    @(negedge line_in);
    k = 0;
    while (line_in === 1'b0)
    begin
      @(negedge pclk);
      if (line_in === 1'b0) k++;
    end
    low_len = k;
  end
endmodule
